// ===== dv/fabric_slipper.sv
`timescale 1ns/100ps
`default_nettype none
// fabric side slip request, one per go, held long enough to be synchronised
module fabric_slipper (
    // clock and request
    input wire logic mclk,
    input wire logic go,
    // slip pin
    output logic slip
);
    logic [2:0] t_q = 3'h0;
    // three clocks high, three low; go is ignored meanwhile
    always_ff @(posedge mclk) begin
        if (t_q != 3'h0) begin
            t_q <= t_q - 3'h1;
        end else if (go) begin
            t_q <= 3'h6;
        end
    end
    assign slip = (t_q > 3'h3);
endmodule // fabric_slipper
`default_nettype wire

// ===== dv/slip_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches the slave handshake and both data paths at the top ports
module slip_checker
    import lane_slip_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus
    input wire lane_slip_pkg::apb_req_t apb_req,
    input wire lane_slip_pkg::apb_rsp_t apb_rsp,
    // data paths
    input wire logic [NUM_CH-1:0][W-1:0] tx_word,
    input wire logic [NUM_CH-1:0][lane_slip_pkg::TX_STD_SEL_W-1:0] tx_bnd_sel,
    input wire logic [NUM_CH-1:0][W-1:0] tx_ser_word,
    input wire logic [NUM_CH-1:0] rx_slip,
    input wire logic [NUM_CH-1:0][lane_slip_pkg::BND_OUT_W-1:0] rx_bnd_pos
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // delay by n bits across the word edge, clamped to one bit less than a word
    function automatic logic [W-1:0] shl(input logic [W-1:0] c, p, input logic [4:0] n);
        logic [2*W-1:0] j;
        j = {c, p} >> (W - ((n > W-1) ? W-1 : n));
        return j[W-1:0];
    endfunction

    property p_ready_lat;
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
    endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("late ready");
    property p_ready_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_ready_req;
        apb_rsp.pready |-> apb_req.psel && apb_req.penable;
    endproperty
    a_ready_req: assert property (p_ready_req) else $error("stray ready");
    property p_err_ready;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("bad error");
    // per lane: level slip, independent count, one step per slip
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        property p_tx;
            $past(rst_n) && $past(rst_n, 2) |-> tx_ser_word[c] ==
                shl($past(tx_word[c]), $past(tx_word[c], 2), $past(tx_bnd_sel[c]));
        endproperty
        a_tx: assert property (p_tx) else $error("tx slip");
        property p_bnd_step;
            $changed(rx_bnd_pos[c]) |-> rx_bnd_pos[c] == $past(rx_bnd_pos[c]) + 5'h01
                || rx_bnd_pos[c] == 5'h00;
        endproperty
        a_bnd_step: assert property (p_bnd_step) else $error("bnd step");
        property p_bnd_cause;
            $changed(rx_bnd_pos[c]) |-> $past(rx_slip[c], 2);
        endproperty
        a_bnd_cause: assert property (p_bnd_cause) else $error("bnd cause");
    end
endmodule // slip_checker
bind lane_bitslip_bit_reversal slip_checker #(.NUM_CH(NUM_CH), .W(W)) u_chk (.mclk(mclk),
    .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .tx_word(tx_word),
    .tx_bnd_sel(tx_bnd_sel), .tx_ser_word(tx_ser_word), .rx_slip(rx_slip),
    .rx_bnd_pos(rx_bnd_pos));
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
// standard build, byte lanes, two channels
module tb;
    import lane_slip_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [1:0][7:0] txw = '0, txo, rxw = '0, rxo;
    logic [1:0][4:0] sel = '0, bnd;
    logic go = 1'b0;
    logic slip0;
    logic [31:0] rd;
    logic er;
    int mismatches = 0, n_compared = 0, k;
    // word, lane 0 select, lane 1 select, lane 0 result, lane 1 result
    logic [39:0] rows [4] = '{40'hBC00_01BC_79, 40'hBC07_015E_79, 40'hBC09_005E_BC,
        40'hFC03_02E7_F3};

    always #50 mclk = ~mclk;

    lane_bitslip_bit_reversal #(.NUM_CH(2), .W(8), .ENHANCED(1'b0)) dut (.mclk(mclk),
        .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .tx_word(txw), .tx_slip_cnt('0),
        .tx_bnd_sel(sel), .tx_ser_word(txo), .rx_des_word(rxw), .rx_slip({1'b0, slip0}),
        .rx_core_word(rxo), .rx_bnd_pos(bnd));
    fabric_slipper u_fab (.mclk(mclk), .go(go), .slip(slip0));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer, entered just after an edge; waits for ready with no bound of its own
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hF};
        @(posedge mclk);
        req.penable <= 1'b1;
        // look just after each edge so the registered answer has settled
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (rsp.pready !== 1'b1);
        cmp(rsp.pready, 32'h1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        // the edge at which ready is sampled high completes the transfer
        @(posedge mclk);
        req <= '0;
        // one idle edge so a following call never reassigns req in this time step
        @(posedge mclk);
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang cuts the run short
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, REG_CTRL, 32'h0);
        cmp(rd, 32'h1);
        apb(1'b1, 8'h0C, 32'h1);
        cmp(er, 32'h1);
        // row loop: the word is held two clocks so both halves of the shift match
        foreach (rows[i]) begin
            txw <= {2{rows[i][39:32]}};
            sel <= {rows[i][20:16], rows[i][28:24]};
            repeat (2) @(posedge mclk);
            #1;
            cmp(txo[0], rows[i][15:8]);
            cmp(txo[1], rows[i][7:0]);
            @(posedge mclk);
        end
        $display("tx slip done");
        // alignment loop: slip lane 0 until the pattern shows, lane 1 untouched
        rxw <= {2{8'hBC}};
        k = 0;
        while (rxo[0] !== 8'h5E && k < 10) begin
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            repeat (9) @(posedge mclk);
            k++;
            cmp(bnd[0], k % 8);
        end
        cmp(k, 7);
        cmp(bnd[1], 0);
        apb(1'b1, REG_RXREV, 32'h1);
        repeat (3) @(posedge mclk);
        cmp(rxo[0], 8'h7A);
        cmp(rxo[1], 8'hBC);
        // manual mode keeps reversal but refuses slips
        apb(1'b1, REG_CTRL, {30'h0, ALN_MANUAL});
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (9) @(posedge mclk);
        cmp(bnd[0], 7);
        cmp(rxo[0], 8'h7A);
        $display("rx slip done");
        // second reset in mid-run clears the boundary and the enables
        rst_n <= 1'b0;
        @(posedge mclk);
        cmp(bnd[0], 0);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, REG_RXREV, 32'h0);
        cmp(rd, 32'h0);
        $display("reset done");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire

// ===== verilog/lane_bitslip_bit_reversal.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lane_bitslip_bit_reversal
    import lane_slip_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int W = 64,
    parameter bit ENHANCED = 1'b1,
    parameter bit TX_BITREV = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus
    input wire lane_slip_pkg::apb_req_t apb_req,
    output lane_slip_pkg::apb_rsp_t apb_rsp,
    // transmit side from fabric and toward serializer
    input wire logic [NUM_CH-1:0][W-1:0] tx_word,
    input wire logic [NUM_CH-1:0][lane_slip_pkg::TX_ENH_SLIP_W-1:0] tx_slip_cnt,
    input wire logic [NUM_CH-1:0][lane_slip_pkg::TX_STD_SEL_W-1:0] tx_bnd_sel,
    output logic [NUM_CH-1:0][W-1:0] tx_ser_word,
    // receive side from deserializer and toward fabric
    input wire logic [NUM_CH-1:0][W-1:0] rx_des_word,
    input wire logic [NUM_CH-1:0] rx_slip,
    output logic [NUM_CH-1:0][W-1:0] rx_core_word,
    output logic [NUM_CH-1:0][lane_slip_pkg::BND_OUT_W-1:0] rx_bnd_pos
);
    import lane_slip_pkg::*;

    // widths the shifter and the register map can serve
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must lie in 1..4");
    end
    if (W < 8 || W > 64) begin : g_bad_w
        $error("W must lie in 8..64");
    end
    if (!ENHANCED && W > 32) begin : g_bad_std_w
        $error("standard path word is at most 32 bits");
    end
    if (ENHANCED && TX_BITREV) begin : g_bad_rev
        $error("transmit bit reversal exists only in the standard path");
    end

    localparam logic [BND_CNT_W-1:0] BND_MAX = BND_CNT_W'(W - 1);

    // whole state of the block
    typedef struct packed {
        logic [NUM_CH-1:0][W-1:0] tx_prev;
        logic [NUM_CH-1:0][W-1:0] rx_prev;
        logic [NUM_CH-1:0][W-1:0] tx_out;
        logic [NUM_CH-1:0][W-1:0] rx_out;
        logic [NUM_CH-1:0][BND_CNT_W-1:0] rx_bnd;
        logic [NUM_CH-1:0][SYNC_STAGES-1:0] slip_sync;
        logic [1:0] amode;
        logic [NUM_CH-1:0] rx_rev;
        apb_st_t ast;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } st_t;

    st_t st_q;
    st_t st_d;

    logic [NUM_CH-1:0][BND_CNT_W-1:0] tx_amt;
    logic [NUM_CH-1:0][W-1:0] tx_shifted;
    logic [NUM_CH-1:0][W-1:0] rx_shifted;
    logic [NUM_CH-1:0] rx_rev_eff;

    // clamp a requested slip to the largest the word allows
    function automatic logic [BND_CNT_W-1:0] clamp_slip(input logic [BND_CNT_W-1:0] n);
        return (n > BND_MAX) ? BND_MAX : n;
    endfunction

    // true for the three aligner modes that are defined
    function automatic logic mode_valid(input logic [1:0] m);
        return (m == ALN_MANUAL) || (m == ALN_SLIP) || (m == ALN_SYNC);
    endfunction

    // per-channel slip amounts and reverse enables
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (ENHANCED) begin
                tx_amt[c] = clamp_slip(tx_slip_cnt[c]);
            end else begin
                tx_amt[c] = clamp_slip(BND_CNT_W'(tx_bnd_sel[c]));
            end
            // the enhanced build never reverses on receive
            rx_rev_eff[c] = !ENHANCED && st_q.rx_rev[c] && mode_valid(st_q.amode);
        end
    end

    // one shifter pair per lane, each lane steered by its own controls and the shared aligner mode
    for (genvar c = 0; c < NUM_CH; c++) begin : g_lane
        lane_word_shift #(
            .W(W),
            .CW(BND_CNT_W),
            .REV_FIRST(1'b1)
        ) u_tx_shift (
            .cur(tx_word[c]),
            .prev(st_q.tx_prev[c]),
            .amount(tx_amt[c]),
            .rev(TX_BITREV),
            .word(tx_shifted[c])
        );

        lane_word_shift #(
            .W(W),
            .CW(BND_CNT_W),
            .REV_FIRST(1'b0)
        ) u_rx_shift (
            .cur(rx_des_word[c]),
            .prev(st_q.rx_prev[c]),
            .amount(st_q.rx_bnd[c]),
            .rev(rx_rev_eff[c]),
            .word(rx_shifted[c])
        );
    end

    // next state: datapath, slip counters and the apb slave
    always_comb begin
        logic slip_edge;
        logic slip_allowed;
        logic acc;
        logic [31:0] rd;
        logic hit;
        slip_edge = 1'b0;
        slip_allowed = 1'b0;
        acc = 1'b0;
        rd = 32'h0000_0000;
        hit = 1'b0;
        st_d = st_q;

        // datapath words: tx slip is applied every cycle from the level on the inputs, rx slip from the boundary counter
        for (int c = 0; c < NUM_CH; c++) begin
            st_d.tx_prev[c] = TX_BITREV ? tx_word[c] : tx_word[c];
            st_d.tx_out[c] = tx_shifted[c];
            st_d.rx_prev[c] = rx_des_word[c];
            st_d.rx_out[c] = rx_shifted[c];
        end

        // slip pin: three stages, an edge counts once stage two is high and stage three still low
        slip_allowed = ENHANCED || (st_q.amode == ALN_SLIP);
        for (int c = 0; c < NUM_CH; c++) begin
            st_d.slip_sync[c] = {st_q.slip_sync[c][1:0], rx_slip[c]};
            // a pulse shorter than one clock may be missed by the sampler
            slip_edge = st_q.slip_sync[c][1] && !st_q.slip_sync[c][2];
            if (slip_edge && slip_allowed) begin
                if (st_q.rx_bnd[c] >= BND_MAX) begin
                    st_d.rx_bnd[c] = '0; // wrap after the last boundary
                end else begin
                    st_d.rx_bnd[c] = BND_CNT_W'(st_q.rx_bnd[c] + BND_CNT_W'(1));
                end
            end
        end

        // register read mux
        unique case (apb_req.paddr)
            REG_CTRL: begin
                rd[CTRL_AMODE_LSB +: 2] = st_q.amode;
                hit = 1'b1;
            end
            REG_RXREV: begin
                rd[NUM_CH-1:0] = st_q.rx_rev;
                hit = 1'b1;
            end
            REG_BND: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    rd[c*BND_FIELD_W +: BND_CNT_W] = st_q.rx_bnd[c];
                end
                hit = 1'b1;
            end
            default: begin
                rd = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase

        // apb slave: one wait state, write lands at the completing edge
        acc = apb_req.psel && apb_req.penable;
        unique case (st_q.ast)
            APB_IDLE: begin
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
                if (acc) begin
                    st_d.ast = APB_WAIT;
                    st_d.pready = 1'b1;
                    st_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
                    st_d.pslverr = !hit; // unmapped address answers with an error
                end
            end
            APB_WAIT: begin
                // master samples pready here, so the write takes effect now
                if (apb_req.pwrite && hit && apb_req.pstrb[0]) begin
                    if (apb_req.paddr == REG_CTRL) begin
                        st_d.amode = apb_req.pwdata[CTRL_AMODE_LSB +: 2];
                    end
                    if (apb_req.paddr == REG_RXREV) begin
                        st_d.rx_rev = apb_req.pwdata[NUM_CH-1:0];
                    end
                end
                st_d.ast = APB_DONE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
                st_d.prdata = 32'h0000_0000;
            end
            APB_DONE: begin
                // penable is low for at least one cycle before the next access
                st_d.ast = APB_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
            end
            default: begin
                st_d.ast = APB_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
            end
        endcase
    end

    // single state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.amode <= CTRL_AMODE_RST;
            st_q.rx_rev <= NUM_CH'(RXREV_RST);
            st_q.ast <= APB_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    always_comb begin
        apb_rsp.pready = st_q.pready;
        apb_rsp.prdata = st_q.prdata;
        apb_rsp.pslverr = st_q.pslverr;
        tx_ser_word = st_q.tx_out;
        rx_core_word = st_q.rx_out;
        for (int c = 0; c < NUM_CH; c++) begin
            rx_bnd_pos[c] = st_q.rx_bnd[c][BND_OUT_W-1:0];
        end
    end

endmodule // lane_bitslip_bit_reversal
`default_nettype wire

// ===== verilog/lane_slip_pkg.sv
`default_nettype none
package lane_slip_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RXREV = 8'h04;
    localparam logic [7:0] REG_BND = 8'h08;

    // control register field positions and reset values
    localparam int CTRL_AMODE_LSB = 0;
    localparam logic [1:0] CTRL_AMODE_RST = 2'h1;
    localparam logic [7:0] RXREV_RST = 8'h00;

    // word aligner modes of the standard receive path
    localparam logic [1:0] ALN_MANUAL = 2'h0;
    localparam logic [1:0] ALN_SLIP = 2'h1;
    localparam logic [1:0] ALN_SYNC = 2'h2;

    // widths of the slip controls
    localparam int TX_ENH_SLIP_W = 6;
    localparam int TX_STD_SEL_W = 5;
    localparam int BND_CNT_W = 6;
    localparam int BND_OUT_W = 5;
    localparam int BND_FIELD_W = 8;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // apb slave phases
    typedef enum logic [2:0] {
        APB_IDLE = 3'b001,
        APB_WAIT = 3'b010,
        APB_DONE = 3'b100
    } apb_st_t;

    // one apb request as the master drives it
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    // apb answer as the slave drives it
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;

endpackage
`default_nettype wire

// ===== verilog/lane_word_shift.sv
`timescale 1ns/100ps
`default_nettype none
// delays the bit stream by a number of bits across the word edge, with optional reversal
module lane_word_shift #(
    parameter int W = 64,
    parameter int CW = 6,
    parameter bit REV_FIRST = 1'b0
) (
    // words
    input wire logic [W-1:0] cur,
    input wire logic [W-1:0] prev,
    // controls
    input wire logic [CW-1:0] amount,
    input wire logic rev,
    // result
    output logic [W-1:0] word
);

    logic [W-1:0] cur_r;
    logic [W-1:0] prev_r;
    logic [W-1:0] slipped;
    logic [2*W-1:0] cat;

    // bit order swap of a full word, msb becomes lsb
    function automatic logic [W-1:0] flip(input logic [W-1:0] v);
        logic [W-1:0] r;
        r = '0;
        for (int i = 0; i < W; i++) begin
            r[i] = v[W-1-i];
        end
        return r;
    endfunction

    // reversal before the slip on transmit, after it on receive
    always_comb begin
        cur_r = (REV_FIRST && rev) ? flip(cur) : cur;
        prev_r = (REV_FIRST && rev) ? flip(prev) : prev;
        cat = {cur_r, prev_r};
        if (amount == '0) begin
            slipped = cur_r;
        end else begin
            slipped = W'(cat >> (W - int'(amount))); // lsb first: earlier bits come from older word
        end
        word = (!REV_FIRST && rev) ? flip(slipped) : slipped;
    end

endmodule // lane_word_shift
`default_nettype wire
